// *** lcc_logic_cell.sv ***
// package of shared constants and the single logic cell of the slice
`timescale 1ns/1ps
`default_nettype none

package lcc_pkg;
	// ------------------------------------------------------------
	// cell geometry
	// ------------------------------------------------------------
	localparam int          LUT_INPUTS        = 4;
	localparam int          LUT_W             = 16;
	localparam int          CELLS_PER_CLUSTER = 10;
	localparam int          CHAIN_CELLS       = 9;
	localparam int          CTRL_CELL         = 0;
	localparam int          CHAIN_FIRST       = 1;
	localparam int          NUM_CLUSTERS      = 4;
	localparam int          CLK_PERIOD_NS     = 25;
	// ------------------------------------------------------------
	// table layout in arithmetic mode
	// ------------------------------------------------------------
	localparam int          ARITH_SUM_BASE    = 0;
	localparam int          ARITH_CARRY_BASE  = 8;
	localparam logic [15:0] ADDER_CFG         = 16'hE896;
	localparam logic        CELL_Q_RST        = 1'h0;
	localparam logic        CARRY_ZERO        = 1'h0;

	// ------------------------------------------------------------
	// four-input table lookup
	// ------------------------------------------------------------
	function automatic logic lut4(input logic [15:0] cfg, input logic [3:0] sel);
		lut4 = cfg[sel];
	endfunction
endpackage

module lcc_logic_cell
	import lcc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// configuration
	input  wire logic [15:0] lut_cfg,
	input  wire logic        arith,
	input  wire logic        bypass,
	input  wire logic        cin_as_d3,
	input  wire logic        fb_en,
	// data and carry
	input  wire logic [3:0]  data,
	input  wire logic        carry_in,
	// cluster-wide controls
	input  wire logic        sclr,
	input  wire logic        sload,
	// results
	output logic             comb_out,
	output logic             cell_out,
	output logic             carry_out,
	output logic             q
);
	logic       q_r;
	logic       q_nxt;
	logic [3:0] d_eff;
	logic [3:0] sel;

	// ------------------------------------------------------------
	// table and carry logic
	// ------------------------------------------------------------
	always_comb begin
		d_eff = data;
		if (fb_en) begin
			d_eff[0] = q_r;
		end
		if (arith) begin
			sel       = {1'b0, carry_in, d_eff[1:0]};
			comb_out  = lut4(lut_cfg, sel); // RL9 RL13
			carry_out = lut4(lut_cfg, sel | 4'(ARITH_CARRY_BASE)); // RL13 RL11
		end else begin
			sel       = {(cin_as_d3 ? carry_in : d_eff[3]), d_eff[2:0]}; // RL3
			comb_out  = lut4(lut_cfg, sel); // RL1
			carry_out = CARRY_ZERO;
		end
	end

	// ------------------------------------------------------------
	// cell register
	// ------------------------------------------------------------
	always_comb begin
		if (sclr) begin
			q_nxt = CELL_Q_RST; // RL15
		end else if (sload) begin
			q_nxt = data[3]; // RL5
		end else begin
			q_nxt = comb_out; // RL10
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q_r <= CELL_Q_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q        = q_r;
	assign cell_out = bypass ? comb_out : q_r; // RL10
endmodule

`default_nettype wire

// *** lcc_slice.sv ***
// row of logic cell clusters with hopping carry chains
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RL1) Every cell has a four-input table that can realise any function of its inputs.
// (RL2) Every cell holds a table, a storage flip-flop and carry logic.
// (RL3) The carry from the lower bit feeds both the table and the carry toward the next bit.
// (RL4) The first cell of a cluster never joins a carry chain.
// (RL5) The first cell's inputs form the cluster's synchronous clear and load enable.
// (RL6) A chain longer than nine cells continues into another cluster.
// (RL7) A long chain hops to the cluster two positions on, last cell to second cell.
// (RL8) A chain stops at the middle of the row and may restart in the second half.
// (RL9) Each adder bit forms the sum of two operand bits and the carry, using n plus one cells.
// (RL10) The register can be bypassed for a plain adder or hold the sum as an accumulator.
// (RL11) Each carry out comes from its own table half and goes straight to the next carry in.
// (RL12) The top carry is placed into an extra cell that drives it out as a plain signal.
// (RL13) In arithmetic mode the table splits into a sum half and a carry half of three inputs.
// (RL14) Clock, clears and load of all cell registers are shared across the cluster.
// (RL15) Synchronous clear wins over synchronous load on the same edge.
// (RL16) A chain's first carry is zero unless a carry-in operand is supplied.
module lcc_slice
	import lcc_pkg::*;
#(
	parameter int NC  = lcc_pkg::NUM_CLUSTERS,
	parameter int CPC = lcc_pkg::CELLS_PER_CLUSTER
)(
	// clock and reset
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST,
	// per-cell configuration
	input  wire logic [NC*CPC*16-1:0] LUT_CFG,
	input  wire logic [NC*CPC-1:0]    ARITH,
	input  wire logic [NC*CPC-1:0]    BYPASS,
	input  wire logic [NC*CPC-1:0]    CIN_AS_D3,
	input  wire logic [NC*CPC-1:0]    FB_EN,
	// per-cluster configuration
	input  wire logic [NC*16-1:0]     LOAD_CFG,
	input  wire logic [NC-1:0]        LINK,
	// data and carry operands
	input  wire logic [NC*CPC*4-1:0]  DATA,
	input  wire logic [NC-1:0]        CARRY_IN,
	// results
	output logic      [NC*CPC-1:0]    CELL_OUT,
	output logic      [NC-1:0]        CARRY_OUT
);
	localparam int HALF = NC / 2;

	logic [NC*CPC-1:0] c_in;
	logic [NC*CPC-1:0] c_out;
	logic [NC*CPC-1:0] comb;
	logic [NC*CPC-1:0] cout_cell;
	logic [NC*CPC-1:0] q;
	logic [NC-1:0]     sclr;
	logic [NC-1:0]     sload;
	logic [NC*CPC-1:0] cell_out_r;
	logic [NC*CPC-1:0] cell_out_nxt;
	logic [NC-1:0]     carry_out_r;
	logic [NC-1:0]     carry_out_nxt;

	// ------------------------------------------------------------
	// cells and carry network
	// ------------------------------------------------------------
	for (genvar k = 0; k < NC; k++) begin : g_cl
		for (genvar j = 0; j < CPC; j++) begin : g_ce
			localparam int I = k * CPC + j;

			if (j == CTRL_CELL) begin : g_ctrl
				assign c_in[I] = CARRY_ZERO; // RL4
			end else if (j == CHAIN_FIRST) begin : g_head
				if (k >= 2 && ((k - 2) / HALF) == (k / HALF)) begin : g_hop
					// hop from last cell two clusters back
					assign c_in[I] = LINK[k] ? c_out[(k-2)*CPC+CPC-1] : CARRY_IN[k]; // RL6 RL7
				end else begin : g_start
					assign c_in[I] = CARRY_IN[k]; // RL8 RL16
				end
			end else begin : g_body
				assign c_in[I] = c_out[I-1]; // RL3 RL11
			end

			// first cell always combinational, it makes controls
			lcc_logic_cell u_cell ( // RL2
				.clk_sys   (CLK_SYS),
				.rst       (RST),
				.lut_cfg   (LUT_CFG[I*16 +: 16]),
				.arith     (j == CTRL_CELL ? 1'b0 : ARITH[I]),
				.bypass    (j == CTRL_CELL ? 1'b1 : BYPASS[I]),
				.cin_as_d3 (j == CTRL_CELL ? 1'b0 : CIN_AS_D3[I]),
				.fb_en     (FB_EN[I]),
				.data      (DATA[I*4 +: 4]),
				.carry_in  (c_in[I]),
				.sclr      (sclr[k]),
				.sload     (sload[k]),
				.comb_out  (comb[I]),
				.cell_out  (cout_cell[I]),
				.carry_out (c_out[I]),
				.q         (q[I])
			);
		end

		// cluster controls from first cell
		assign sclr[k]  = comb[k*CPC+CTRL_CELL]; // RL5 RL14
		assign sload[k] = lut4(LOAD_CFG[k*16 +: 16], DATA[(k*CPC+CTRL_CELL)*4 +: 4]); // RL5 RL14
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_comb begin
		cell_out_nxt = cout_cell;
		for (int k = 0; k < NC; k++) begin
			carry_out_nxt[k] = c_out[k*CPC+CPC-1]; // RL12
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cell_out_r  <= '0;
			carry_out_r <= '0;
		end else begin
			cell_out_r  <= cell_out_nxt;
			carry_out_r <= carry_out_nxt;
		end
	end

	assign CELL_OUT  = cell_out_r;
	assign CARRY_OUT = carry_out_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	for (genvar k = 0; k < NC; k++) begin : g_chk
		localparam int B = k * CPC;

		first_cell_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL4
			c_in[B] == 1'b0 && c_out[B] == 1'b0)
			else $error("first cell joined a carry chain");

		ctrl_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL5
			!FB_EN[B] |-> sclr[k] == LUT_CFG[B*16 + DATA[B*4 +: 4]])
			else $error("cluster clear not from first cell");

		ctrl_load_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL5
			sload[k] == LOAD_CFG[k*16 + DATA[B*4 +: 4]])
			else $error("cluster load not from first cell");

		if (k >= 2 && ((k - 2) / HALF) == (k / HALF)) begin : g_hopc
			carry_hop_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL7
				LINK[k] |-> c_in[B+1] == c_out[(k-2)*CPC+CPC-1])
				else $error("carry did not hop two clusters");
			chain_start_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL16
				!LINK[k] |-> c_in[B+1] == CARRY_IN[k])
				else $error("unlinked chain ignores carry operand");
		end else begin : g_midc
			mid_stop_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL8
				c_in[B+1] == CARRY_IN[k])
				else $error("chain crossed row middle");
		end

		top_carry_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL12
			##1 CARRY_OUT[k] == $past(c_out[B+CPC-1]))
			else $error("top carry not driven out");

		// ------------------------------------------------------------
		// per-cell checks
		// ------------------------------------------------------------
		for (genvar j = 1; j < CPC; j++) begin : g_cc
			localparam int I = B + j;

			sequence s_adder_bit;
				ARITH[I] && BYPASS[I] && !FB_EN[I] && LUT_CFG[I*16 +: 16] == ADDER_CFG;
			endsequence

			sequence s_hold;
				!BYPASS[I] && !sclr[k] && !sload[k];
			endsequence

			adder_sum_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL9
				s_adder_bit |=> CELL_OUT[I] == $past(DATA[I*4] ^ DATA[I*4+1] ^ c_in[I]))
				else $error("adder sum bit wrong");

			adder_carry_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL13
				s_adder_bit |-> c_out[I] == ((DATA[I*4] & DATA[I*4+1])
					| (c_in[I] & (DATA[I*4] ^ DATA[I*4+1]))))
				else $error("adder carry bit wrong");

			accum_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL10
				s_hold ##1 !BYPASS[I] |=> CELL_OUT[I] == $past(comb[I], 2))
				else $error("register did not hold sum");

			clear_wins_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL15
				sclr[k] && sload[k] && !BYPASS[I] ##1 !BYPASS[I] |=> CELL_OUT[I] == 1'b0)
				else $error("clear lost to load");

			sync_load_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL14
				sload[k] && !sclr[k] |=> q[I] == $past(DATA[I*4+3]))
				else $error("cluster load not applied");

			lut_normal_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL1
				!ARITH[I] && !FB_EN[I] && !CIN_AS_D3[I]
					|-> comb[I] == LUT_CFG[I*16 + DATA[I*4 +: 4]])
				else $error("table output wrong");

			carry_feed_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL3
				!ARITH[I] && !FB_EN[I] && CIN_AS_D3[I]
					|-> comb[I] == LUT_CFG[I*16 + {c_in[I], DATA[I*4 +: 3]}])
				else $error("carry in not fed to table");

			reg_path_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL10
				!BYPASS[I] |=> CELL_OUT[I] == $past(q[I]))
				else $error("registered output not shown");

			norm_carry_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL13
				!ARITH[I] |-> c_out[I] == 1'b0)
				else $error("carry out outside arithmetic mode");

			if (j >= 2) begin : g_lnk
				carry_link_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL11
					c_in[I] == c_out[I-1])
					else $error("carry not linked to next bit");
			end
		end
	end
endmodule

`default_nettype wire

// *** lcc_slice_tb.sv ***
// self-checking testbench for the logic cell slice
`timescale 1ns/1ps
`default_nettype none

module lcc_slice_tb;
	import lcc_pkg::*;
	localparam int NC = 8;
	localparam int N  = NC * CELLS_PER_CLUSTER;
	logic              clk_sys;
	logic              rst;
	logic [N*16-1:0]   lut_cfg;
	logic [N-1:0]      arith;
	logic [N-1:0]      bypass;
	logic [N-1:0]      cin_as_d3;
	logic [N-1:0]      fb_en;
	logic [N-1:0]      cell_out;
	logic [NC*16-1:0]  load_cfg;
	logic [NC-1:0]     link;
	logic [NC-1:0]     carry_in;
	logic [NC-1:0]     carry_out;
	logic [N*4-1:0]    data;
	int                miscompares;
	int                tests_run;
	int                cycles;

	lcc_slice #(.NC(NC), .CPC(CELLS_PER_CLUSTER)) dut (
		.CLK_SYS(clk_sys), .RST(rst), .LUT_CFG(lut_cfg), .ARITH(arith),
		.BYPASS(bypass), .CIN_AS_D3(cin_as_d3), .FB_EN(fb_en),
		.LOAD_CFG(load_cfg), .LINK(link), .DATA(data), .CARRY_IN(carry_in),
		.CELL_OUT(cell_out), .CARRY_OUT(carry_out)
	);

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 500) begin
			miscompares++;
			test_done();
		end
	end

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	function automatic int ci(input int k, input int j);
		return k * CELLS_PER_CLUSTER + j;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic test_done();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic set_cell(input int i, input logic [15:0] cfg, input logic ar, input logic [3:0] d);
		lut_cfg[i*16 +: 16] = cfg;
		arith[i] = ar;
		bypass[i] = 1'b1;
		data[i*4 +: 4] = d;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// 17-bit adder: cluster 0 bits 0..8, hop to cluster 2, extra cell last
	task automatic t_add(input logic [17:0] a, input logic [17:0] b, input logic cin);
		logic [17:0] want;
		logic [17:0] seen;
		logic        c;
		logic        c9;
		int          p;
		c = cin;
		@(negedge clk_sys);
		link[2] = 1'b1;
		carry_in[0] = cin;
		for (p = 0; p < 18; p++) begin
			if (p == 17) begin
				set_cell(ci(2, 9), 16'hE8F0, 1'b1, 4'h0);
				want[p] = c;
			end else begin
				set_cell((p < 9) ? ci(0, p + 1) : ci(2, p - 8), ADDER_CFG, 1'b1, {2'h0, b[p], a[p]});
				want[p] = a[p] ^ b[p] ^ c;
				c = (a[p] & b[p]) | (c & (a[p] ^ b[p]));
			end
			if (p == 8) c9 = c;
		end
		@(negedge clk_sys);
		for (p = 0; p < 18; p++) seen[p] = cell_out[(p < 9) ? ci(0, p + 1) : ci(2, p - 8)];
		check(seen, want);
		check(carry_out[0], c9);
	endtask

	// chain head of second half ignores a link across the middle
	task automatic t_half();
		@(negedge clk_sys);
		set_cell(ci(2, 9), ADDER_CFG, 1'b1, 4'h3);
		set_cell(ci(4, 0), ADDER_CFG, 1'b1, 4'h3);
		set_cell(ci(4, 1), ADDER_CFG, 1'b1, 4'h0);
		link[4] = 1'b1;
		carry_in[4] = 1'b0;
		@(negedge clk_sys);
		check(carry_out[2], 1'b1);
		check(cell_out[ci(4, 1)], 1'b0);
		carry_in[4] = 1'b1;
		@(negedge clk_sys);
		check(cell_out[ci(4, 1)], 1'b1);
	endtask

	// every table entry, with carry in standing in for data3 on request
	task automatic t_lut(input logic use_cin);
		localparam logic [15:0] PAT = 16'h6A5C;
		logic [3:0] s;
		int         k;
		for (k = 0; k < 16; k++) begin
			s = 4'(k);
			@(negedge clk_sys);
			set_cell(ci(3, 1), PAT, 1'b0, use_cin ? {~s[3], s[2:0]} : s);
			cin_as_d3[ci(3, 1)] = use_cin;
			carry_in[3] = use_cin & s[3];
			@(negedge clk_sys);
			check(cell_out[ci(3, 1)], PAT[s]);
		end
	endtask

	// two-bit accumulator in cluster 1 with load, count and clear
	task automatic t_acc();
		int a;
		int b;
		int z;
		a = ci(1, 1);
		b = ci(1, 2);
		z = ci(1, 0);
		@(negedge clk_sys);
		set_cell(a, ADDER_CFG, 1'b1, 4'hA);
		set_cell(b, ADDER_CFG, 1'b1, 4'h8);
		bypass[a] = 1'b0;
		bypass[b] = 1'b0;
		fb_en[a] = 1'b1;
		fb_en[b] = 1'b1;
		carry_in[1] = 1'b0;
		load_cfg[31:16] = 16'hC000;
		set_cell(z, 16'h8000, 1'b0, 4'hE);
		@(negedge clk_sys);
		data[z*4 +: 4] = 4'h0;
		@(negedge clk_sys);
		check({cell_out[b], cell_out[a]}, 2'h3);
		@(negedge clk_sys);
		check({cell_out[b], cell_out[a]}, 2'h0);
		data[z*4 +: 4] = 4'hF;
		@(negedge clk_sys);
		check({cell_out[b], cell_out[a]}, 2'h1);
		data[z*4 +: 4] = 4'h0;
		@(negedge clk_sys);
		check({cell_out[b], cell_out[a]}, 2'h0);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		lut_cfg = '0;
		arith = '0;
		bypass = '0;
		cin_as_d3 = '0;
		fb_en = '0;
		load_cfg = '0;
		link = '0;
		carry_in = '0;
		data = '0;
		miscompares = 0;
		tests_run = 0;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		check(|{cell_out, carry_out}, 1'b0);
		rst = 1'b0;
		t_add(18'h1FFFF, 18'h00000, 1'b1);
		t_add(18'h0AAAA, 18'h15555, 1'b0);
		t_add(18'h1F0F3, 18'h0F10D, 1'b1);
		t_half();
		t_lut(1'b0);
		t_lut(1'b1);
		t_acc();
		// let the clear-over-load check run to completion
		repeat (2) @(negedge clk_sys);
		rst = 1'b1;
		#1;
		check(|{cell_out, carry_out}, 1'b0);
		test_done();
	end
endmodule

`default_nettype wire
